// ### hw/ctsi_params.svh
// Summary of operation
// - Sideband word counts only while valid high
// - Eight credits; grant all, then each freed
// - Acknowledge activation once ready for packets
// - Deactivation hint raised on link reset
// - Fourth start taken from fourth position field
`ifndef CTSI_PARAMS_SVH
`define CTSI_PARAMS_SVH
`define CTSI_DATA_W 512
`define CTSI_SIDE_W 100
`define CTSI_CREDITS 8
`define CTSI_CREDIT_W 4
`define CTSI_FIFO_DEPTH 16
`define CTSI_MASK_LSB 0
`define CTSI_POS0_LSB 4
`define CTSI_POS1_LSB 6
`define CTSI_POS2_LSB 8
`define CTSI_POS3_LSB 10
`define CTSI_MASK_NONE 4'h0
`define CTSI_MASK_ONE 4'h1
`define CTSI_MASK_TWO 4'h3
`define CTSI_MASK_THREE 4'h7
`define CTSI_MASK_FOUR 4'hF
`endif

// ### hw/ctsi_pkg.sv
package ctsi_pkg;
   typedef enum logic [1:0] {
      CTSI_STOPPED,
      CTSI_GRANTING,
      CTSI_ACTIVE,
      CTSI_DRAINING
   } ctsi_state_e;
   typedef logic [1:0] ctsi_pos_t;
endpackage

// ### hw/ctsi_fifo.sv
`timescale 1ns/10ps
module ctsi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule

// ### hw/ctsi_top.sv
`timescale 1ns/10ps
`include "ctsi_params.svh"
module ctsi_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`CTSI_DATA_W-1:0] tx_data,
   input wire logic [`CTSI_SIDE_W-1:0] tx_side,
   input wire logic tx_valid,
   output logic credit_grant,
   input wire logic credit_return,
   input wire logic active_req,
   output logic active_ack,
   output logic deact_hint,
   input wire logic link_reset,
   input wire logic vc_link_up,
   output logic pkt_valid,
   input wire logic pkt_ready,
   output logic [`CTSI_DATA_W-1:0] pkt_data,
   output logic [2:0] pkt_start_count,
   output logic [5:0] pkt_start_byte [4],
   output logic pkt_mask_error
);
   import ctsi_pkg::*;

   localparam int FW = `CTSI_DATA_W + 3 + 24 + 1;
   ctsi_state_e state;
   logic [`CTSI_CREDIT_W-1:0] held;
   logic [`CTSI_CREDIT_W-1:0] initial_left;
   logic [`CTSI_CREDIT_W-1:0] freed;
   logic beat_in;
   logic fifo_ready;
   logic fifo_out_valid;
   logic [FW-1:0] fifo_in;
   logic [FW-1:0] fifo_out;
   logic [3:0] packet_start_mask;
   ctsi_pos_t first_start_position;
   ctsi_pos_t second_start_position;
   ctsi_pos_t third_start_position;
   ctsi_pos_t fourth_start_position;
   logic [2:0] start_count;
   logic mask_bad;
   logic [23:0] start_bytes;
   logic link_rst_q1;
   logic link_rst_q2;
   logic up_q1;
   logic up_q2;
   logic req_q1;
   logic req_q2;
   logic grant_now;
   logic grant_freed;

   // Link status pins come from the PCIe side's domain
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_rst_q1 <= 1'b0;
         link_rst_q2 <= 1'b0;
      end else begin
         link_rst_q1 <= link_reset;
         link_rst_q2 <= link_rst_q1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         up_q1 <= 1'b0;
         up_q2 <= 1'b0;
      end else begin
         up_q1 <= vc_link_up;
         up_q2 <= up_q1;
      end
   end

   // The request may come from logic on another clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q1 <= 1'b0;
         req_q2 <= 1'b0;
      end else begin
         req_q1 <= active_req;
         req_q2 <= req_q1;
      end
   end

   // Sideband decoded every cycle, mask error gated by valid; a beat without credit is dropped
   // so the held count cannot wrap below zero
   assign beat_in = tx_valid && (held != '0) && fifo_ready;
   assign packet_start_mask = tx_side[`CTSI_MASK_LSB +: 4];
   assign first_start_position = tx_side[`CTSI_POS0_LSB +: 2];
   assign second_start_position = tx_side[`CTSI_POS1_LSB +: 2];
   assign third_start_position = tx_side[`CTSI_POS2_LSB +: 2];
   assign fourth_start_position = tx_side[`CTSI_POS3_LSB +: 2];

   always_comb begin
      mask_bad = 1'b0;
      case (packet_start_mask)
         `CTSI_MASK_NONE: start_count = 3'h0;
         `CTSI_MASK_ONE: start_count = 3'h1;
         `CTSI_MASK_TWO: start_count = 3'h2;
         `CTSI_MASK_THREE: start_count = 3'h3;
         `CTSI_MASK_FOUR: start_count = 3'h4;
         default: begin
            start_count = 3'h0;
            mask_bad = tx_valid;
         end
      endcase
   end

   // Position code times 16 gives the byte offset
   assign start_bytes = {fourth_start_position, 4'h0,
                         third_start_position, 4'h0,
                         second_start_position, 4'h0,
                         first_start_position, 4'h0};
   assign fifo_in = {mask_bad, start_bytes, start_count, tx_data};

   // Credits guarantee room, so fifo_ready only stalls on misuse
   ctsi_fifo #(
      .WIDTH(FW),
      .DEPTH(`CTSI_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(beat_in),
      .in_ready(fifo_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(pkt_ready),
      .out_data(fifo_out),
      .level()
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= CTSI_STOPPED;
      end else begin
         case (state)
            CTSI_STOPPED: begin
               if (req_q2 && up_q2 && !link_rst_q2) begin
                  state <= CTSI_GRANTING;
               end
            end
            CTSI_GRANTING: begin
               if (link_rst_q2 || !req_q2) begin
                  state <= CTSI_DRAINING;
               end else if (initial_left == 4'h1) begin
                  state <= CTSI_ACTIVE;
               end
            end
            CTSI_ACTIVE: begin
               if (link_rst_q2 || !req_q2 || !up_q2) begin
                  state <= CTSI_DRAINING;
               end
            end
            CTSI_DRAINING: begin
               if (held == '0 && !link_rst_q2) begin
                  state <= CTSI_STOPPED;
               end
            end
            default: state <= CTSI_STOPPED;
         endcase
      end
   end

   // Freed credits wait for the acknowledge, so the opening burst stays
   // exactly eight pulses even when beats drain during it
   assign grant_freed = (state == CTSI_ACTIVE) && active_ack &&
                        (freed != '0);
   assign grant_now = (state == CTSI_GRANTING) || grant_freed;
   assign credit_grant = grant_now;

   // Opening burst counter: reloaded while stopped, spent while granting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         initial_left <= '0;
      end else if (state == CTSI_STOPPED) begin
         initial_left <= 4'(`CTSI_CREDITS);
      end else if (state == CTSI_GRANTING) begin
         initial_left <= initial_left - 1'b1;
      end
   end

   // Held counts credits the application owns
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held <= '0;
      end else if (state == CTSI_DRAINING && credit_return) begin
         held <= '0;
      end else begin
         held <= held + {3'h0, grant_now} - {3'h0, beat_in};
      end
   end

   // Freed counts popped beats not yet granted back; pops during the
   // burst are kept, otherwise those credits would be lost for good
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         freed <= '0;
      end else if (state == CTSI_STOPPED) begin
         freed <= '0;
      end else if (state == CTSI_GRANTING || state == CTSI_ACTIVE) begin
         freed <= freed + {3'h0, fifo_out_valid && pkt_ready}
                  - {3'h0, grant_freed};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_ack <= 1'b0;
      end else begin
         active_ack <= (state == CTSI_ACTIVE) && req_q2;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         deact_hint <= 1'b0;
      end else begin
         deact_hint <= link_rst_q2;
      end
   end

   assign pkt_valid = fifo_out_valid;
   assign pkt_data = fifo_out[`CTSI_DATA_W-1:0];
   assign pkt_start_count = fifo_out[`CTSI_DATA_W +: 3];
   assign pkt_mask_error = fifo_out[FW-1];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pkt_start_byte[i] = fifo_out[`CTSI_DATA_W + 3 + 6*i +: 6];
      end
   end
endmodule

// ### verif/ctsi_assertions.sv
`timescale 1ns/10ps
`include "ctsi_params.svh"
module ctsi_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_valid,
   input wire logic credit_grant,
   input wire logic active_req,
   input wire logic active_ack,
   input wire logic deact_hint,
   input wire logic link_reset,
   input wire logic pkt_valid,
   input wire logic pkt_ready,
   input wire logic [`CTSI_DATA_W-1:0] pkt_data,
   input wire logic [2:0] pkt_start_count,
   input wire logic pkt_mask_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   hint_on_reset_a: assert property (link_reset [*4] |-> deact_hint)
      else $error("hint late");
   ack_drops_a: assert property (!active_req [*5] |-> !active_ack)
      else $error("ack without request");
   grant_burst_a: assert property ($rose(credit_grant) && !active_ack
      |-> credit_grant [*8] ##1 !credit_grant) else $error("burst not 8");
   ack_after_a: assert property ($fell(credit_grant) && !active_ack
      |=> active_ack) else $error("ack late");
   beat_out_a: assert property (tx_valid && active_ack && !pkt_valid
      |=> pkt_valid) else $error("beat lost");
   beat_held_a: assert property (pkt_valid && !pkt_ready
      |=> pkt_valid && $stable(pkt_data)) else $error("beat moved");
   mask_bad_a: assert property (pkt_valid && pkt_mask_error
      |-> pkt_start_count == 3'h0) else $error("bad mask counted");
   pop_grant_a: assert property (pkt_valid && pkt_ready && active_ack
      |=> credit_grant) else $error("no grant on pop");
endmodule
bind ctsi_top ctsi_checker chk (.clk, .rst, .tx_valid, .credit_grant,
   .active_req, .active_ack, .deact_hint, .link_reset, .pkt_valid,
   .pkt_ready, .pkt_data, .pkt_start_count, .pkt_mask_error);

// ### verif/ctsi_app_model.sv
`timescale 1ns/10ps
`include "ctsi_params.svh"
module ctsi_app_model (
   input wire logic clk,
   input wire logic credit_grant,
   input wire logic deact_hint,
   output logic [`CTSI_DATA_W-1:0] tx_data,
   output logic [`CTSI_SIDE_W-1:0] tx_side,
   output logic tx_valid,
   output logic credit_return,
   output logic active_req
);
   int credits = 0;
   initial begin
      tx_data = '0;
      tx_side = '0;
      tx_valid = 1'b0;
      credit_return = 1'b0;
      active_req = 1'b0;
   end
   always @(posedge clk) begin
      credit_return <= deact_hint;
      if (deact_hint) begin
         credits <= 0;
      end else begin
         credits <= credits + int'(credit_grant) - int'(tx_valid);
      end
   end
   task automatic set_req(input logic v);
      @(posedge clk);
      active_req <= v;
   endtask
   // A beat still on the bus counts against the credits seen mid-cycle
   task automatic send(input logic [`CTSI_SIDE_W-1:0] s,
                       input logic [`CTSI_DATA_W-1:0] d);
      @(negedge clk);
      while (credits <= int'(tx_valid)) begin
         @(posedge clk);
         tx_valid <= 1'b0;
         @(negedge clk);
      end
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_side <= s;
      tx_data <= d;
   endtask
   // Released lines show the inverse so stale data cannot pass for new
   task automatic idle();
      @(posedge clk);
      tx_valid <= 1'b0;
      tx_data <= ~tx_data;
      tx_side <= ~tx_side;
   endtask
endmodule

// ### verif/test_coherent_tx_stream_ingress.sv
`timescale 1ns/10ps
`include "ctsi_params.svh"
module test_coherent_tx_stream_ingress;
   logic clk, rst, link_reset, vc_link_up, pkt_ready;
   logic [`CTSI_DATA_W-1:0] tx_data, pkt_data;
   logic [`CTSI_SIDE_W-1:0] tx_side;
   logic tx_valid, credit_grant, credit_return, active_req, active_ack;
   logic deact_hint, pkt_valid, pkt_mask_error;
   logic [2:0] pkt_start_count;
   logic [5:0] pkt_start_byte [4];
   int n_fail = 0, n_checks = 0, cyc = 0;
   ctsi_top dut (.clk, .rst, .tx_data, .tx_side, .tx_valid, .credit_grant,
      .credit_return, .active_req, .active_ack, .deact_hint, .link_reset,
      .vc_link_up, .pkt_valid, .pkt_ready, .pkt_data, .pkt_start_count,
      .pkt_start_byte, .pkt_mask_error);
   ctsi_app_model app (.clk, .credit_grant, .deact_hint, .tx_data,
      .tx_side, .tx_valid, .credit_return, .active_req);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [`CTSI_DATA_W-1:0] seen, exp,
                        input string what);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %0t %s", $time, what);
      end
   endtask
   task automatic close_out();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic t_activate();
      int g = 0;
      check(active_ack, 1'b0, "ack idle");
      app.set_req(1'b1);
      repeat (6) @(posedge clk);
      check(credit_grant, 1'b0, "grant while link down");
      check(active_ack, 1'b0, "ack while link down");
      vc_link_up <= 1'b1;
      repeat (40) begin
         @(posedge clk);
         if (credit_grant === 1'b1) g++;
         if (active_ack === 1'b1) break;
      end
      check(g, 8, "burst");
      check(active_ack, 1'b1, "ack");
   endtask
   task automatic t_masks();
      logic [3:0] m [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h5};
      logic [2:0] n [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
      logic [1:0] p [4];
      for (int i = 0; i < 6; i++)
         app.send({88'h0, 6'h3E, 2'(i), m[i]},
            {16{32'(i + 'hA5)}});
      app.idle();
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         p = '{2'(i), 2'h2, 2'h3, 2'h3};
         check(pkt_valid, 1'b1, "valid");
         check(pkt_data, {16{32'(i + 'hA5)}}, "data");
         check(pkt_start_count, n[i], "count");
         check(pkt_mask_error, i == 5, "mask");
         for (int k = 0; k < n[i]; k++)
            check(pkt_start_byte[k], {p[k], 4'h0}, "pos");
         pkt_ready <= 1'b1;
         @(posedge clk);
         pkt_ready <= 1'b0;
         repeat (2) @(posedge clk);
      end
      check(app.credits, 8, "refill");
   endtask
   task automatic t_deact();
      link_reset <= 1'b1;
      repeat (6) @(posedge clk);
      check(deact_hint, 1'b1, "hint");
      check(app.credits, 0, "returned");
      app.set_req(1'b0);
      repeat (8) @(posedge clk);
      check(active_ack, 1'b0, "ack drop");
      link_reset <= 1'b0;
      repeat (6) @(posedge clk);
      check(deact_hint, 1'b0, "hint clear");
   endtask
   initial begin
      rst = 1'b1;
      link_reset = 1'b0;
      vc_link_up = 1'b0;
      pkt_ready = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_activate();
      $display("done activate");
      t_masks();
      $display("done masks");
      t_deact();
      $display("done deactivate");
      close_out();
   end
endmodule
